// ==== bench/pss_assertions.sv ====
// port assertions of the save and restore block
`timescale 1ns/100ps
`include "pss_cfg.svh"
module pss_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wrValid,
  input wire logic [15:0] wrIndex,
  input wire logic [7:0] wrSub,
  input wire logic [31:0] wrData,
  input wire logic restartReq,
  input wire logic busy,
  input wire logic bootDone,
  input wire logic nvmReq,
  input wire pss_pkg::pss_op_t nvmOp,
  input wire logic [2:0] nvmCat,
  input wire logic nvmAck
);
  import pss_pkg::*;
  logic go, isSave, isErase, isBoot, allWalk;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  assign go = wrValid && !busy;
  assign isSave = go && wrIndex == `PSS_IDX_STORE && wrData == `PSS_MAGIC_SAVE;
  assign isErase = go && wrIndex == `PSS_IDX_RESTORE && wrData == `PSS_MAGIC_DISCARD;
  assign isBoot = wrValid && wrIndex == `PSS_IDX_REBOOT && wrSub == `PSS_SUB_REBOOT
    && wrData == `PSS_MAGIC_REBOOT;
  // marks a walk begun on subindex 01 until the block goes idle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      allWalk <= 1'b0;
    end else if (go && wrSub == `PSS_SUB_ALL) begin
      allWalk <= 1'b1;
    end else if (!busy) begin
      allWalk <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////
  save_all_a: assert property (
    isSave && wrSub == `PSS_SUB_ALL |=> nvmReq && nvmOp == PSS_OP_SAVE && nvmCat == 3'h0)
    else $error("save all did not start");
  save_tune_a: assert property (
    isSave && wrSub == `PSS_SUB_TUNE |=> nvmReq && nvmOp == PSS_OP_SAVE && nvmCat == 3'h4)
    else $error("tuning save wrong category");
  erase_eth_a: assert property (
    isErase && wrSub == `PSS_SUB_ETH |=> nvmReq && nvmOp == PSS_OP_ERASE && nvmCat == 3'h5)
    else $error("ethernet discard wrong category");
  all_spare_a: assert property (
    allWalk && nvmReq |-> nvmCat[2:1] != 2'h2)
    else $error("subindex 01 touched tuning or ethernet");
  boot_load_a: assert property (
    nvmReq && !bootDone |-> nvmOp == PSS_OP_LOAD)
    else $error("boot walk is not a load");
  reboot_pulse_a: assert property (
    isBoot |=> restartReq)
    else $error("restart not requested");
  reboot_cause_a: assert property (
    restartReq |-> $past(isBoot))
    else $error("restart without its value");
  junk_quiet_a: assert property (
    go && wrIndex == `PSS_IDX_STORE && wrData != `PSS_MAGIC_SAVE |=> !nvmReq)
    else $error("other value started a save");
  cat_order_a: assert property (
    nvmReq && nvmAck ##1 nvmReq |-> nvmCat > $past(nvmCat))
    else $error("categories out of order");
  cover property (isSave && wrSub == `PSS_SUB_ALL);
  cover property (isErase && wrSub == `PSS_SUB_ALL);
  cover property (restartReq);
endmodule
bind pss_save_restore pss_checker i_chk (.mclk(mclk), .arst_n(arst_n), .wrValid(wrValid),
  .wrIndex(wrIndex), .wrSub(wrSub), .wrData(wrData), .restartReq(restartReq), .busy(busy),
  .bootDone(bootDone), .nvmReq(nvmReq), .nvmOp(nvmOp), .nvmCat(nvmCat), .nvmAck(nvmAck));

// ==== bench/pss_nvm_model.sv ====
// stand-in nonvolatile store facing the save and restore block
`timescale 1ns/100ps
module pss_nvm_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic nvmReq,
  input wire pss_pkg::pss_op_t nvmOp,
  input wire logic [2:0] nvmCat,
  input wire logic [63:0] nvmWrData,
  output logic nvmAck,
  output logic [63:0] nvmRdData
);
  import pss_pkg::*;
  logic [7:0] held = 8'h00;
  logic [63:0] mark = 64'h0;
  logic [2:0] dly;
  // inverted off the ack so a late sample cannot pass
  assign nvmRdData = nvmAck ? mark : ~mark;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      nvmAck <= 1'b0;
      dly <= 3'h0;
    end else begin
      nvmAck <= nvmReq && !nvmAck && dly >= {slow, 2'h0};
      dly <= nvmReq && !nvmAck ? dly + 3'h1 : 3'h0;
    end
  end
  // no reset: contents outlive the block's reset
  always @(posedge mclk) begin
    if (nvmReq && nvmAck && nvmOp != PSS_OP_LOAD) begin
      held[nvmCat] <= nvmOp == PSS_OP_SAVE;
      if (nvmCat == 3'h7) begin
        mark <= nvmOp == PSS_OP_SAVE ? nvmWrData : 64'h0;
      end
    end
  end
endmodule

// ==== bench/pss_save_restore_bench.sv ====
// testbench of the save and restore block
`timescale 1ns/100ps
`include "pss_cfg.svh"
module pss_save_restore_bench;
  import pss_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic wrValid = 1'b0;
  logic wrSavable = 1'b0;
  logic slow = 1'b0;
  logic [15:0] wrIndex = 16'h0000;
  logic [15:0] rdIndex = 16'h0000;
  logic [7:0] wrSub = 8'h00;
  logic [7:0] rdSub = 8'h00;
  logic [31:0] wrData = 32'h00000000;
  logic [31:0] rdData, got;
  logic restartReq, busy, bootDone, nvmReq, nvmAck;
  pss_op_t nvmOp;
  logic [2:0] nvmCat;
  logic [63:0] nvmWrData, nvmRdData;
  logic [7:0] exp;
  logic [7:0] subs [6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0C};
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 mclk = ~mclk;
  pss_save_restore i_dut (.mclk(mclk), .arst_n(arst_n), .wrValid(wrValid),
    .wrIndex(wrIndex), .wrSub(wrSub), .wrData(wrData), .wrSavable(wrSavable),
    .rdIndex(rdIndex), .rdSub(rdSub), .rdData(rdData), .restartReq(restartReq), .busy(busy),
    .bootDone(bootDone), .nvmReq(nvmReq), .nvmOp(nvmOp), .nvmCat(nvmCat),
    .nvmWrData(nvmWrData), .nvmAck(nvmAck), .nvmRdData(nvmRdData));
  pss_nvm_model i_nvm (.mclk(mclk), .arst_n(arst_n), .slow(slow), .nvmReq(nvmReq),
    .nvmOp(nvmOp), .nvmCat(nvmCat), .nvmWrData(nvmWrData), .nvmAck(nvmAck),
    .nvmRdData(nvmRdData));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
    input logic sv);
    @(negedge mclk);
    wrValid = 1'b1;
    wrIndex = i;
    wrSub = s;
    wrData = d;
    wrSavable = sv;
    @(negedge mclk);
    wrValid = 1'b0;
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s);
    @(negedge mclk);
    rdIndex = i;
    rdSub = s;
    @(negedge mclk);
    got = rdData;
  endtask
  task automatic idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge mclk);
    // done flags register one edge after busy drops
    @(negedge mclk);
    chk("busy", 32'h0, {31'h0, busy});
  endtask
  // polls the store flag as a master must before trusting the copy
  task automatic poll(input logic [7:0] s);
    for (int i = 0; i < 300 && got !== 32'h1; i++) rd(`PSS_IDX_STORE, s);
    chk("store flag", 32'h1, got);
    got = 32'h0;
    idle;
  endtask
  task automatic mask(input logic [7:0] e);
    chk("saved set", {24'h0, e}, {24'h0, i_nvm.held});
  endtask
  task automatic rst;
    arst_n = 1'b0;
    repeat (12) @(negedge mclk);
    arst_n = 1'b1;
    idle;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    got = 32'h0;
    rst;
    chk("boot done", 32'h1, {31'h0, bootDone});
    wr(`PSS_IDX_STORE, `PSS_SUB_COMM, 32'h12345678, 1'b1);
    idle;
    mask(8'h00);
    $display("test boot and refusal done");
    slow = 1'b1;
    wr(`PSS_IDX_VERIFY, `PSS_SUB_VDATE, 32'h0000A5C3, 1'b0);
    wr(`PSS_IDX_VERIFY, `PSS_SUB_VTIME, 32'h00005A3C, 1'b0);
    wr(`PSS_IDX_STORE, `PSS_SUB_ALL, `PSS_MAGIC_SAVE, 1'b1);
    wr(`PSS_IDX_RESTORE, `PSS_SUB_ALL, `PSS_MAGIC_DISCARD, 1'b0);
    poll(`PSS_SUB_ALL);
    mask(8'hCF);
    slow = 1'b0;
    rst;
    rd(`PSS_IDX_VERIFY, `PSS_SUB_VDATE);
    chk("date reload", 32'h0000A5C3, got);
    rd(`PSS_IDX_VERIFY, `PSS_SUB_VTIME);
    chk("time reload", 32'h00005A3C, got);
    wr(`PSS_IDX_RESTORE, `PSS_SUB_ALL, `PSS_MAGIC_DISCARD, 1'b0);
    idle;
    mask(8'h00);
    rd(`PSS_IDX_VERIFY, `PSS_SUB_VDATE);
    chk("date kept", 32'h0000A5C3, got);
    wr(16'h6060, 8'h00, 32'h00000001, 1'b1);
    rd(`PSS_IDX_VERIFY, `PSS_SUB_VDATE);
    chk("date cleared", 32'h0, got);
    $display("test save all and reload done");
    exp = 8'h00;
    foreach (subs[i]) begin
      wr(`PSS_IDX_STORE, subs[i], `PSS_MAGIC_SAVE, 1'b1);
      poll(subs[i]);
      exp[i] = 1'b1;
      mask(exp);
    end
    wr(`PSS_IDX_STORE, `PSS_SUB_ALL, `PSS_MAGIC_SAVE, 1'b1);
    poll(`PSS_SUB_ALL);
    mask(8'hFF);
    wr(`PSS_IDX_RESTORE, `PSS_SUB_ALL, 32'h64616F6D, 1'b0);
    idle;
    mask(8'hFF);
    wr(`PSS_IDX_RESTORE, `PSS_SUB_ALL, `PSS_MAGIC_DISCARD, 1'b0);
    idle;
    mask(8'h30);
    exp = 8'h30;
    foreach (subs[i]) begin
      wr(`PSS_IDX_RESTORE, subs[i], `PSS_MAGIC_DISCARD, 1'b0);
      idle;
      exp[i] = 1'b0;
      mask(exp);
    end
    $display("test category codes done");
    wr(`PSS_IDX_REBOOT, `PSS_SUB_REBOOT, 32'h746F6F63, 1'b0);
    chk("restart", 32'h0, {31'h0, restartReq});
    wr(`PSS_IDX_REBOOT, `PSS_SUB_REBOOT, `PSS_MAGIC_REBOOT, 1'b0);
    chk("restart", 32'h1, {31'h0, restartReq});
    $display("test restart done");
    close_out;
  end
endmodule

// ==== rtl/pss_cfg.svh ====
// constants of the parameter save and restore block
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH
`define PSS_IDX_STORE 16'h1010
`define PSS_IDX_RESTORE 16'h1011
`define PSS_IDX_VERIFY 16'h1020
`define PSS_IDX_REBOOT 16'h2800
`define PSS_MAGIC_SAVE 32'h65766173
`define PSS_MAGIC_DISCARD 32'h64616F6C
`define PSS_MAGIC_REBOOT 32'h746F6F62
`define PSS_SUB_ALL 8'h01
`define PSS_SUB_COMM 8'h02
`define PSS_SUB_APP 8'h03
`define PSS_SUB_USER 8'h04
`define PSS_SUB_MOVE 8'h05
`define PSS_SUB_TUNE 8'h06
`define PSS_SUB_ETH 8'h0C
`define PSS_SUB_REBOOT 8'h01
`define PSS_SUB_VDATE 8'h01
`define PSS_SUB_VTIME 8'h02
`define PSS_DONE_VALUE 32'h00000001
`define PSS_CAT_COMM 0
`define PSS_CAT_APP 1
`define PSS_CAT_USER 2
`define PSS_CAT_MOVE 3
`define PSS_CAT_TUNE 4
`define PSS_CAT_ETH 5
`define PSS_CAT_DRIVE 6
`define PSS_CAT_MARK 7
`define PSS_MASK_ALL 8'hCF
`define PSS_MASK_BOOT 8'hFF
`define PSS_SLOT_NONE 3'h7
`define PSS_STORE_RESET 32'h00000000
`define PSS_VERIFY_RESET 32'h00000000
`endif

// ==== rtl/pss_nvm_walker.sv ====
// walks a category mask, one nonvolatile operation per category
`timescale 1ns/100ps
`include "pss_cfg.svh"
module pss_nvm_walker #(
  parameter int CATS = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic startValid,
  input wire pss_pkg::pss_op_t startOp,
  input wire logic [CATS-1:0] startMask,
  output logic startReady,
  output logic donePulse,
  output logic nvmReq,
  output pss_pkg::pss_op_t nvmOp,
  output logic [2:0] nvmCat,
  input wire logic nvmAck
);
  import pss_pkg::*;

  pss_state_t state;
  logic [CATS-1:0] remain;
  logic [2:0] lowCat;

  function automatic logic [2:0] lowestBit(input logic [CATS-1:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = CATS - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  assign lowCat = lowestBit(remain);
  assign startReady = (state == PSS_ST_IDLE);
  assign nvmReq = (state == PSS_ST_WALK) && (remain != '0);
  assign nvmCat = lowCat;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= PSS_ST_IDLE;
      remain <= '0;
      nvmOp <= PSS_OP_LOAD;
      donePulse <= 1'b0;
    end else begin
      donePulse <= 1'b0;
      case (state)
        PSS_ST_IDLE: begin
          if (startValid) begin
            // whole categories only, never single objects
            remain <= startMask;
            nvmOp <= startOp;
            state <= PSS_ST_WALK;
          end
        end
        PSS_ST_WALK: begin
          if (remain == '0) begin
            donePulse <= 1'b1;
            state <= PSS_ST_IDLE;
          end else if (nvmAck) begin
            remain[lowCat] <= 1'b0;
          end
        end
        default: begin
          state <= PSS_ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== rtl/pss_pkg.sv ====
// types of the parameter save and restore block
package pss_pkg;
  typedef enum logic [1:0] {
    PSS_OP_LOAD = 2'h0,
    PSS_OP_SAVE = 2'h1,
    PSS_OP_ERASE = 2'h2
  } pss_op_t;
  typedef enum logic [1:0] {
    PSS_ST_IDLE = 2'h1,
    PSS_ST_WALK = 2'h2
  } pss_state_t;
endpackage

// ==== rtl/pss_save_restore.sv ====
// object save, discard, reboot and modification marker logic
// What this block does
// - save magic on store subindex saves category
// - finished save writes 1 into subindex
// - store subindex selects its category set
// - discard magic on restore subindex erases copy
// - restore 01 spares tuning and Ethernet
// - discard leaves live values untouched
// - reboot magic on 2800:01 requests restart
// - tuning erased only by restore subindex 06
// - tuning category holds motor and encoder data
// - drive submode and feedback travel together
// - marker entries saved with save-all
// - savable write clears marker entries, except writes to 1020 or to store subindex 01
// - reset reloads every saved category
// - only whole categories are ever stored
`timescale 1ns/100ps
`include "pss_cfg.svh"
module pss_save_restore #(
  parameter int CATS = 8,
  parameter int SLOTS = 7
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wrValid,
  input wire logic [15:0] wrIndex,
  input wire logic [7:0] wrSub,
  input wire logic [31:0] wrData,
  input wire logic wrSavable,
  input wire logic [15:0] rdIndex,
  input wire logic [7:0] rdSub,
  output logic [31:0] rdData,
  output logic restartReq,
  output logic busy,
  output logic bootDone,
  output logic nvmReq,
  output pss_pkg::pss_op_t nvmOp,
  output logic [2:0] nvmCat,
  output logic [63:0] nvmWrData,
  input wire logic nvmAck,
  input wire logic [63:0] nvmRdData
);
  import pss_pkg::*;

  logic [31:0] storeVal [SLOTS];
  logic [31:0] verifyDate;
  logic [31:0] verifyTime;
  logic bootPending;
  logic activeSave;
  logic [2:0] activeSlot;
  logic startValid;
  pss_op_t startOp;
  logic [CATS-1:0] startMask;
  logic startReady;
  logic donePulse;
  logic [2:0] wrSlot;
  logic [2:0] rdSlot;
  logic storeHit;
  logic restoreHit;
  logic saveCmd;
  logic eraseCmd;

  ////////////////////////////////////////////////////////////////////////////
  // subindex to slot: 01..06 map to 0..5, 0C to 6
  function automatic logic [2:0] slotOf(input logic [7:0] sub);
    logic [2:0] s;
    case (sub)
      `PSS_SUB_ALL: s = 3'h0;
      `PSS_SUB_COMM: s = 3'h1;
      `PSS_SUB_APP: s = 3'h2;
      `PSS_SUB_USER: s = 3'h3;
      `PSS_SUB_MOVE: s = 3'h4;
      `PSS_SUB_TUNE: s = 3'h5;
      `PSS_SUB_ETH: s = 3'h6;
      default: s = `PSS_SLOT_NONE;
    endcase
    return s;
  endfunction

  // save-all and factory reset leave tuning and Ethernet alone;
  // drive and the marker only ride along with the all slot
  function automatic logic [CATS-1:0] maskOf(input logic [2:0] slot);
    logic [CATS-1:0] m;
    m = '0;
    case (slot)
      3'h0: m = `PSS_MASK_ALL;
      3'h1: m[`PSS_CAT_COMM] = 1'b1;
      3'h2: m[`PSS_CAT_APP] = 1'b1;
      3'h3: m[`PSS_CAT_USER] = 1'b1;
      3'h4: m[`PSS_CAT_MOVE] = 1'b1;
      3'h5: m[`PSS_CAT_TUNE] = 1'b1;
      3'h6: m[`PSS_CAT_ETH] = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction

  assign wrSlot = slotOf(wrSub);
  assign rdSlot = slotOf(rdSub);
  assign storeHit = wrValid && (wrIndex == `PSS_IDX_STORE) && (wrSlot != `PSS_SLOT_NONE);
  assign restoreHit = wrValid && (wrIndex == `PSS_IDX_RESTORE)
    && (wrSlot != `PSS_SLOT_NONE);
  // anything but the exact magic word starts nothing
  assign saveCmd = storeHit && (wrData == `PSS_MAGIC_SAVE);
  assign eraseCmd = restoreHit && (wrData == `PSS_MAGIC_DISCARD);

  ////////////////////////////////////////////////////////////////////////////
  // boot reload has priority; a command while busy is not queued
  always_comb begin
    startValid = 1'b0;
    startOp = PSS_OP_LOAD;
    startMask = '0;
    if (bootPending) begin
      startValid = startReady;
      startMask = `PSS_MASK_BOOT;
    end else if (saveCmd) begin
      startValid = startReady;
      startOp = PSS_OP_SAVE;
      startMask = maskOf(wrSlot);
    end else if (eraseCmd) begin
      startValid = startReady;
      startOp = PSS_OP_ERASE;
      startMask = maskOf(wrSlot);
    end
  end

  assign busy = !startReady || bootPending;
  assign nvmWrData = {verifyDate, verifyTime};

  pss_nvm_walker #(
    .CATS(CATS)
  ) u_walker (
    .mclk(mclk),
    .arst_n(arst_n),
    .startValid(startValid),
    .startOp(startOp),
    .startMask(startMask),
    .startReady(startReady),
    .donePulse(donePulse),
    .nvmReq(nvmReq),
    .nvmOp(nvmOp),
    .nvmCat(nvmCat),
    .nvmAck(nvmAck)
  );

  ////////////////////////////////////////////////////////////////////////////
  // boot sequencing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bootPending <= 1'b1;
      bootDone <= 1'b0;
    end else begin
      if (bootPending && startReady) begin
        bootPending <= 1'b0;
      end
      if (!bootPending && donePulse) begin
        bootDone <= 1'b1;
      end
    end
  end

  // remember which store slot asked, to report its completion
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      activeSave <= 1'b0;
      activeSlot <= `PSS_SLOT_NONE;
    end else if (startValid) begin
      activeSave <= (startOp == PSS_OP_SAVE);
      activeSlot <= wrSlot;
    end else if (donePulse) begin
      activeSave <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // store subindex values; completion beats a master write in the same cycle
  for (genvar g = 0; g < SLOTS; g++) begin : gen_store
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        storeVal[g] <= `PSS_STORE_RESET;
      end else if (donePulse && activeSave && (activeSlot == 3'(g))) begin
        storeVal[g] <= `PSS_DONE_VALUE;
      end else if (storeHit && (wrSlot == 3'(g))) begin
        storeVal[g] <= wrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modification marker; a discard never touches live values, so only
  // boot reload writes it from the stored copy
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      verifyDate <= `PSS_VERIFY_RESET;
      verifyTime <= `PSS_VERIFY_RESET;
    end else if (nvmReq && nvmAck && (nvmOp == PSS_OP_LOAD)
        && (nvmCat == 3'(`PSS_CAT_MARK))) begin
      verifyDate <= nvmRdData[63:32];
      verifyTime <= nvmRdData[31:0];
    end else if (wrValid && (wrIndex == `PSS_IDX_VERIFY)) begin
      if (wrSub == `PSS_SUB_VDATE) begin
        verifyDate <= wrData;
      end
      if (wrSub == `PSS_SUB_VTIME) begin
        verifyTime <= wrData;
      end
    end else if (wrValid && !(storeHit && wrSlot == 3'h0)
        && (wrSavable || wrIndex == `PSS_IDX_STORE)) begin
      verifyDate <= `PSS_VERIFY_RESET;
      verifyTime <= `PSS_VERIFY_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // restart request pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      restartReq <= 1'b0;
    end else begin
      restartReq <= wrValid && (wrIndex == `PSS_IDX_REBOOT)
        && (wrSub == `PSS_SUB_REBOOT) && (wrData == `PSS_MAGIC_REBOOT);
    end
  end

  // registered read of the objects held here; others read zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= '0;
    end else if (rdIndex == `PSS_IDX_STORE && rdSlot != `PSS_SLOT_NONE) begin
      rdData <= storeVal[rdSlot];
    end else if (rdIndex == `PSS_IDX_VERIFY && rdSub == `PSS_SUB_VDATE) begin
      rdData <= verifyDate;
    end else if (rdIndex == `PSS_IDX_VERIFY && rdSub == `PSS_SUB_VTIME) begin
      rdData <= verifyTime;
    end else begin
      rdData <= '0;
    end
  end
endmodule
